// ===== arrc_pkg.sv
// constants shared by the analog reference and regulator control block
package arrc_pkg;
    localparam logic [7:0] REF_CTRL_ADDR = 8'hD1;
    localparam logic [7:0] REG_CTRL_ADDR = 8'hC9;
    localparam logic [7:0] REF_CTRL_RESET = 8'h00;
    localparam logic [7:0] REG_CTRL_RESET = 8'h10;
    // reference_control fields
    localparam int REF_BUFFER_ON_BIT = 0;
    localparam int ANALOG_BIAS_FORCE_BIT = 1;
    localparam int TEMP_SENSOR_ON_BIT = 2;
    localparam int REF_SOURCE_SELECT_BIT = 3;
    localparam int REF_LEVEL_SELECT_BIT = 4;
    localparam int ZERO_TC_BIAS_FORCE_BIT = 5;
    localparam logic [7:0] REF_CTRL_WMASK = 8'h3F;
    // regulator_control fields
    localparam int DROPOUT_BIT = 0;
    localparam int REG_LEVEL_SELECT_BIT = 4;
    localparam int REG_DISABLE_BIT = 7;
    localparam int SYNC_STAGES = 2;
endpackage

// ===== arrc_sync.sv
// multi-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module arrc_sync #(
    parameter int STAGES = 2
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_async,
    output logic o_sync
);
    logic [STAGES-1:0] stage_q;

    initial begin
        if (STAGES < 2) begin
            $error("arrc_sync needs at least two stages");
        end
    end

    // stage 0 is read only by stage 1
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            stage_q <= '0;
        end else if (i_ce) begin
            stage_q <= {stage_q[STAGES-2:0], i_async};
        end
    end

    assign o_sync = stage_q[STAGES-1];
endmodule
`default_nettype wire

// ===== arrc_ctrl.sv
// reference control and regulator control registers with dropout interrupt path
// Contract
// - reference source bit 3: 0 uses the reference pin, 1 uses the supply rail.
// - bias enable to analog forced high when converter, sensor or oscillator is on.
// - bias force bit 1: 0 automatic, 1 keeps bias generator on.
// - reference level bit 4: 0 selects 1.5 V, 1 selects 2.2 V.
// - temperature sensor bit 2: 1 turns sensor on, 0 off.
// - reference buffer bit 0: 1 drives internal reference onto the pin.
// - reference control bits 7:6 read 00b; software writes 00b.
// - regulator enabled after reset; software may disable it.
// - regulator output selectable between 2.1 V and 2.6 V.
// - dropout interrupt raised on dropout, only while its enable bit is set.
// - dropout interrupt has no latched pending flag.
// - dropout indicator clears in hardware when dropout ends; software polls it.
// - dropout indicator reads 1 in or near dropout, else 0.
// - regulator disable bit 7: 0 enables, 1 disables.
// - regulator level bit 4: 0 gives 2.1 V, 1 gives 2.6 V, reset default.
`timescale 1ns/1ps
`default_nettype none
module arrc_ctrl #(
    parameter int SYNC_STAGES = arrc_pkg::SYNC_STAGES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    input wire logic i_adc_enabled,
    input wire logic i_osc_enabled,
    input wire logic i_dropout_raw,
    input wire logic i_dropout_int_enable,
    input wire logic i_dropout_int_priority,
    output logic o_ref_source_vdd,
    output logic o_ref_level_high,
    output logic o_temp_sensor_on,
    output logic o_ref_buffer_on,
    output logic o_analog_bias_on,
    output logic o_zero_tc_bias_force,
    output logic o_regulator_enable,
    output logic o_regulator_level_high,
    output logic o_dropout_irq,
    output logic o_dropout_irq_high_pri
);
    logic [7:0] ref_ctrl_q;
    logic reg_disable_q;
    logic reg_level_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit_q;
    logic dropout_sync;

    initial begin
        if (SYNC_STAGES < 2) begin
            $error("arrc_ctrl needs at least two synchroniser stages");
        end
    end

    // address decode
    wire sel_ref = (i_sfr_addr == arrc_pkg::REF_CTRL_ADDR);
    wire sel_reg = (i_sfr_addr == arrc_pkg::REG_CTRL_ADDR);
    wire wr_ref = i_ce && i_sfr_wr && sel_ref;
    wire wr_reg = i_ce && i_sfr_wr && sel_reg;

    // the analog level may change at any time, so it is brought in through flops
    arrc_sync #(
        .STAGES(SYNC_STAGES)
    ) u_dropout_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async(i_dropout_raw),
        .o_sync(dropout_sync)
    );

    // reserved bits are never stored, so they always read back as zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ref_ctrl_q <= arrc_pkg::REF_CTRL_RESET;
        end else if (wr_ref) begin
            ref_ctrl_q <= i_sfr_wdata & arrc_pkg::REF_CTRL_WMASK;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            reg_disable_q <= arrc_pkg::REG_CTRL_RESET[arrc_pkg::REG_DISABLE_BIT];
            reg_level_q <= arrc_pkg::REG_CTRL_RESET[arrc_pkg::REG_LEVEL_SELECT_BIT];
        end else if (wr_reg) begin
            reg_disable_q <= i_sfr_wdata[arrc_pkg::REG_DISABLE_BIT];
            reg_level_q <= i_sfr_wdata[arrc_pkg::REG_LEVEL_SELECT_BIT];
        end
    end

    // outputs to the analog circuits
    assign o_ref_buffer_on = ref_ctrl_q[arrc_pkg::REF_BUFFER_ON_BIT];
    assign o_temp_sensor_on = ref_ctrl_q[arrc_pkg::TEMP_SENSOR_ON_BIT];
    assign o_ref_source_vdd = ref_ctrl_q[arrc_pkg::REF_SOURCE_SELECT_BIT];
    assign o_ref_level_high = ref_ctrl_q[arrc_pkg::REF_LEVEL_SELECT_BIT];
    assign o_zero_tc_bias_force = ref_ctrl_q[arrc_pkg::ZERO_TC_BIAS_FORCE_BIT];
    wire bias_force = ref_ctrl_q[arrc_pkg::ANALOG_BIAS_FORCE_BIT];
    wire bias_demand = i_adc_enabled || o_temp_sensor_on || i_osc_enabled;
    assign o_analog_bias_on = bias_force || bias_demand;
    assign o_regulator_enable = !reg_disable_q;
    assign o_regulator_level_high = reg_level_q;

    // level request with no pending flag: it drops as soon as dropout ends
    assign o_dropout_irq = dropout_sync && i_dropout_int_enable;
    assign o_dropout_irq_high_pri = o_dropout_irq && i_dropout_int_priority;

    // read view: bias bit shows the effective enable, as software sees it forced
    wire [7:0] ref_view = {ref_ctrl_q[7:2], o_analog_bias_on, ref_ctrl_q[0]};
    wire [7:0] reg_view = {reg_disable_q, 2'h0, reg_level_q, 3'h0, dropout_sync};

    always_comb begin
        rdata_d = 8'h00;
        if (sel_ref) begin
            rdata_d = ref_view;
        end else if (sel_reg) begin
            rdata_d = reg_view;
        end
    end

    // read data is registered; unmapped addresses answer zero with no hit
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else if (i_ce) begin
            if (i_sfr_rd) begin
                rdata_q <= rdata_d;
            end
            hit_q <= i_sfr_rd && (sel_ref || sel_reg);
        end
    end

    assign o_sfr_rdata = rdata_q;
    assign o_sfr_hit = hit_q;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_ref_write_fields: assert property (
        wr_ref |=> o_ref_source_vdd == $past(i_sfr_wdata[3]) &&
            o_ref_level_high == $past(i_sfr_wdata[4]) &&
            o_temp_sensor_on == $past(i_sfr_wdata[2]) &&
            o_ref_buffer_on == $past(i_sfr_wdata[0]) &&
            o_zero_tc_bias_force == $past(i_sfr_wdata[5]))
        else $error("reference control fields do not follow the write");

    a_ref_reserved_zero: assert property (
        i_ce && i_sfr_rd && sel_ref |=> o_sfr_rdata[7:6] == 2'h0 && o_sfr_hit)
        else $error("reserved reference bits read non-zero");

    a_bias_demand_forced: assert property (
        (i_adc_enabled || i_osc_enabled || o_temp_sensor_on) |-> o_analog_bias_on)
        else $error("bias not forced on by demand");

    a_bias_force_hold: assert property (
        wr_ref && i_sfr_wdata[1] |=> o_analog_bias_on)
        else $error("bias force bit did not keep bias on");

    // with no demand and no force the generator is left to its automatic off state
    a_bias_auto_off: assert property (
        !ref_ctrl_q[arrc_pkg::ANALOG_BIAS_FORCE_BIT] && !i_adc_enabled && !i_osc_enabled &&
            !ref_ctrl_q[arrc_pkg::TEMP_SENSOR_ON_BIT] |-> !o_analog_bias_on)
        else $error("bias on with no demand and no force");

    a_reg_disable_write: assert property (
        wr_reg |=> o_regulator_enable == !$past(i_sfr_wdata[7]))
        else $error("regulator enable does not follow disable bit");

    a_reg_level_write: assert property (
        wr_reg |=> o_regulator_level_high == $past(i_sfr_wdata[4]))
        else $error("regulator level does not follow write");

    a_irq_gated_enable: assert property (
        o_dropout_irq |-> i_dropout_int_enable && dropout_sync)
        else $error("dropout request without enable or dropout");

    a_irq_no_latch: assert property (
        $fell(dropout_sync) |-> !o_dropout_irq)
        else $error("dropout request outlived the dropout");

    a_dropout_sync_delay: assert property (
        $past(i_ce) && $past(i_ce, 2) && !$past(i_rst) && !$past(i_rst, 2)
            |-> dropout_sync == $past(i_dropout_raw, 2))
        else $error("dropout level not two cycles behind the pin");

    a_dropout_read_view: assert property (
        i_ce && i_sfr_rd && sel_reg |=> o_sfr_rdata[0] == $past(dropout_sync) &&
            o_sfr_rdata[6:5] == 2'h0 && o_sfr_rdata[3:1] == 3'h0)
        else $error("regulator control read view wrong");

    a_reg_read_view: assert property (
        i_ce && i_sfr_rd && sel_reg |=> o_sfr_rdata[7] == !$past(o_regulator_enable) &&
            o_sfr_rdata[4] == $past(o_regulator_level_high))
        else $error("regulator control read view disagrees with outputs");

    // a low enable must hold every register, read data included
    a_ce_freeze: assert property (
        !i_ce |=> $stable(ref_ctrl_q) && $stable(reg_disable_q) && $stable(reg_level_q) &&
            $stable(o_sfr_rdata) && $stable(o_sfr_hit))
        else $error("state changed while clock enable low");

    a_unmapped_no_hit: assert property (
        i_ce && i_sfr_rd && !sel_ref && !sel_reg |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("unmapped read answered");

    a_hit_one_cycle: assert property (
        o_sfr_hit && i_ce && !i_sfr_rd |=> !o_sfr_hit)
        else $error("read hit stood longer than one cycle");

    a_irq_priority_gate: assert property (
        o_dropout_irq_high_pri |-> o_dropout_irq && i_dropout_int_priority)
        else $error("high priority request without request or priority");

    c_ref_written: cover property (wr_ref ##1 o_ref_buffer_on);
    c_bias_by_demand: cover property (i_adc_enabled && !bias_force && o_analog_bias_on);
    c_dropout_irq: cover property ($rose(o_dropout_irq) ##[1:20] $fell(dropout_sync));
    c_reg_disabled: cover property (wr_reg ##1 !o_regulator_enable);
    c_unmapped_read: cover property (i_ce && i_sfr_rd && !sel_ref && !sel_reg);
endmodule
`default_nettype wire

// ===== arrc_ctrl_bench.sv
// self-checking bench for the reference and regulator control block
`timescale 1ns/1ps
`default_nettype none
module arrc_ctrl_bench;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic i_adc_enabled = 1'b0, i_osc_enabled = 1'b0, i_dropout_raw = 1'b0;
    logic i_dropout_int_enable = 1'b0, i_dropout_int_priority = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
    logic [7:0] o_sfr_rdata, exp;
    logic o_sfr_hit, o_ref_source_vdd, o_ref_level_high, o_temp_sensor_on, o_ref_buffer_on;
    logic o_analog_bias_on, o_zero_tc_bias_force, o_regulator_enable, o_regulator_level_high;
    logic o_dropout_irq, o_dropout_irq_high_pri;
    int fail_count = 0, comparisons = 0, cycles = 0;
    // field order matches reference_control bits 5:0
    wire [7:0] ref_v = {2'b00, o_zero_tc_bias_force, o_ref_level_high, o_ref_source_vdd,
        o_temp_sensor_on, o_analog_bias_on, o_ref_buffer_on};
    wire [7:0] reg_v = {4'h0, o_regulator_enable, o_regulator_level_high, o_dropout_irq,
        o_dropout_irq_high_pri};
    localparam logic [7:0] RF = arrc_pkg::REF_CTRL_ADDR;
    localparam logic [7:0] RG = arrc_pkg::REG_CTRL_ADDR;

    arrc_ctrl u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_sfr_addr(i_sfr_addr),
        .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
        .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_adc_enabled(i_adc_enabled),
        .i_osc_enabled(i_osc_enabled), .i_dropout_raw(i_dropout_raw),
        .i_dropout_int_enable(i_dropout_int_enable),
        .i_dropout_int_priority(i_dropout_int_priority), .o_ref_source_vdd(o_ref_source_vdd),
        .o_ref_level_high(o_ref_level_high), .o_temp_sensor_on(o_temp_sensor_on),
        .o_ref_buffer_on(o_ref_buffer_on), .o_analog_bias_on(o_analog_bias_on),
        .o_zero_tc_bias_force(o_zero_tc_bias_force), .o_regulator_enable(o_regulator_enable),
        .o_regulator_level_high(o_regulator_level_high), .o_dropout_irq(o_dropout_irq),
        .o_dropout_irq_high_pri(o_dropout_irq_high_pri));

    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask

    // one strobe cycle, then a low cycle, so back-to-back calls never overlap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_sfr_addr <= a;
        i_sfr_wdata <= d;
        i_sfr_wr <= 1'b1;
        @(posedge i_mclk);
        i_sfr_wr <= 1'b0;
        @(negedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge i_mclk);
        i_sfr_addr <= a;
        i_sfr_rd <= 1'b1;
        @(posedge i_mclk);
        i_sfr_rd <= 1'b0;
        @(negedge i_mclk);
        chk("read data", e, o_sfr_rdata);
        chk("read hit", {7'h00, h}, {7'h00, o_sfr_hit});
    endtask

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        chk("ref outputs", 8'h00, ref_v);
        chk("reg outputs", 8'h0C, reg_v);
        rd(RF, 8'h00, 1'b1);
        rd(RG, 8'h10, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            // the sensor bit also demands the bias generator
            exp = (8'h01 << i) | ((i == 2) ? 8'h02 : 8'h00);
            wr(RF, 8'h01 << i);
            chk("ref outputs", exp, ref_v);
            rd(RF, exp, 1'b1);
        end
        wr(RF, 8'h3F);
        rd(RF, 8'h3F, 1'b1);
        wr(RF, 8'h00);
        $display("test reference fields done");
        for (int k = 0; k < 3; k++) begin
            @(posedge i_mclk);
            {i_osc_enabled, i_adc_enabled} <= 2'b01 << k;
            exp = (k < 2) ? 8'h02 : 8'h00;
            @(negedge i_mclk);
            chk("bias on", exp, ref_v);
            rd(RF, exp, 1'b1);
        end
        $display("test bias forcing done");
        wr(RG, 8'h90);
        chk("reg outputs", 8'h04, reg_v);
        rd(RG, 8'h90, 1'b1);
        wr(RG, 8'h2F);
        chk("reg outputs", 8'h08, reg_v);
        rd(RG, 8'h00, 1'b1);
        wr(RG, 8'h10);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00, 1'b0);
        chk("ref outputs", 8'h00, ref_v);
        @(posedge i_mclk);
        i_ce <= 1'b0;
        wr(RF, 8'h3F);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        @(negedge i_mclk);
        chk("ref outputs", 8'h00, ref_v);
        $display("test regulator and refusals done");
        @(posedge i_mclk);
        i_dropout_int_enable <= 1'b1;
        @(posedge i_mclk);
        i_dropout_raw <= 1'b1;
        @(negedge i_mclk);
        chk("irq early", 8'h0C, reg_v);
        @(negedge i_mclk);
        chk("irq early", 8'h0C, reg_v);
        @(negedge i_mclk);
        chk("irq raised", 8'h0E, reg_v);
        @(posedge i_mclk);
        i_dropout_int_priority <= 1'b1;
        @(negedge i_mclk);
        chk("irq priority", 8'h0F, reg_v);
        rd(RG, 8'h11, 1'b1);
        @(posedge i_mclk);
        i_dropout_int_enable <= 1'b0;
        @(negedge i_mclk);
        chk("irq masked", 8'h0C, reg_v);
        @(posedge i_mclk);
        i_dropout_raw <= 1'b0;
        repeat (3) @(negedge i_mclk);
        rd(RG, 8'h10, 1'b1);
        @(posedge i_mclk);
        i_dropout_int_enable <= 1'b1;
        @(negedge i_mclk);
        chk("irq ended", 8'h0C, reg_v);
        @(posedge i_mclk);
        i_dropout_raw <= 1'b1;
        repeat (3) @(negedge i_mclk);
        chk("irq again", 8'h0F, reg_v);
        @(posedge i_mclk);
        i_dropout_raw <= 1'b0;
        @(negedge i_mclk);
        chk("irq tail", 8'h0F, reg_v);
        repeat (2) @(negedge i_mclk);
        chk("irq dropped", 8'h0C, reg_v);
        $display("test dropout done");
        conclude();
    end
endmodule
`default_nettype wire
